// ===== shared/charger_regs_pkg.sv
// Overview of operation
// RQ1 - Status bits 7:6 report present charge phase
// RQ2 - Write-only ship bit requests storage mode, resets 0
// RQ3 - Reset and overcurrent flags clear when read
// RQ4 - Timer flag survives reads until pin toggle
// RQ5 - Status shows droop, chip-off level, switcher on
// RQ6 - Input overvoltage flag held while condition persists
// RQ7 - Undervoltage flag reports once per new event
// RQ8 - Battery lockout flag held while condition persists
// RQ9 - Mask bits suppress alert, never the reset output
// RQ10 - Fault phase without flags means input limit
// RQ11 - Thermistor enable bit, resets to one
// RQ12 - Thermistor zone code halves current or lowers voltage
// RQ13 - Thermistor absent flag stops charging
// RQ14 - Alert shows faults only, or faults plus charging
// RQ15 - Held faults clear only while deglitch clock runs
// RQ16 - Charge current from span bit and code
// RQ17 - Charge current clamps; all-ones selects resistor
// RQ18 - Host sets one-hot finish code before all-ones
// RQ19 - Fast charge bits disable charger, high impedance
// RQ20 - Finish current from span and code, clamped
// RQ21 - Finish cutoff enable, suppressed by other loops
// RQ22 - Battery target 3.6 V plus code, clamped
// RQ23 - Status register sits at address zero
// RQ24 - Undefined addresses read back all ones
// RQ25 - Unmasked fault rise pulses the alert pin
`default_nettype none
package charger_regs_pkg;
    // Register addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_FAULT = 8'h01;
    localparam logic [7:0] REG_THERM = 8'h02;
    localparam logic [7:0] REG_FAST = 8'h03;
    localparam logic [7:0] REG_FINISH = 8'h04;
    localparam logic [7:0] REG_VBAT = 8'h05;
    localparam logic [7:0] REG_VOUT = 8'h06;
    localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
    // Reset values
    localparam logic [3:0] RST_HIDE = 4'h0;
    localparam logic [7:0] RST_THERM = 8'h88;
    localparam logic [7:0] RST_FAST = 8'h14;
    localparam logic [7:0] RST_FINISH = 8'h0e;
    localparam logic [7:0] RST_VBAT = 8'h78;
    localparam logic [7:0] RST_VOUT = 8'h84;
    // Field positions
    localparam int SHIP_BIT = 5;
    localparam int THERM_ON_BIT = 7;
    localparam int ALERT_STATUS_BIT = 3;
    localparam int CE_BIT = 1;
    localparam int HZ_BIT = 0;
    localparam int CUTOFF_BIT = 1;
    // Codes
    localparam logic [1:0] PHASE_CHARGING = 2'h1;
    localparam logic [1:0] PHASE_FAULT = 2'h3;
    localparam logic [1:0] ZONE_STOP = 2'h1;
    localparam logic [1:0] ZONE_COOL = 2'h2;
    localparam logic [1:0] ZONE_WARM = 2'h3;
    localparam logic [4:0] CODE_EXTERNAL = 5'h1f;
    localparam logic [6:0] SLAVE_ADDR = 7'h6a;
    // Analog set-point arithmetic
    localparam int CHG_BASE0_MA = 5;
    localparam int CHG_STEP0_MA = 1;
    localparam int CHG_MAX0_MA = 35;
    localparam int CHG_BASE1_MA = 40;
    localparam int CHG_STEP1_MA = 10;
    localparam int CHG_MAX1_MA = 300;
    localparam int FIN_BASE0_UA = 500;
    localparam int FIN_STEP0_UA = 500;
    localparam int FIN_MAX0_UA = 5000;
    localparam int FIN_BASE1_UA = 6000;
    localparam int FIN_STEP1_UA = 1000;
    localparam int VBAT_BASE_MV = 3600;
    localparam int VBAT_STEP_MV = 10;
    localparam int VBAT_MAX_MV = 4650;
    localparam int WARM_DROP_MV = 140;
    localparam logic [4:0] ALERT_PULSE_CYCLES = 5'h10;
    // Serial engine states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SHIFT = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_RACK = 5'h10
    } link_state_t;
    // Fault conditions from the analog side
    typedef struct packed {
        logic wake;
        logic reset_cond;
        logic timer;
        logic overcurrent;
        logic lockout;
        logic under;
        logic over;
    } fault_events_t;
    // Status levels from the analog side
    typedef struct packed {
        logic [1:0] phase;
        logic input_droop_active;
        logic switcher_on_flag;
        logic [1:0] zone;
        logic absent;
        logic input_present;
        logic battery_only;
        logic other_loop;
    } analog_status_t;
endpackage
`default_nettype wire

// ===== hdl/charger_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module charger_status_config_regs
    import charger_regs_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic scl_in, // Serial clock level
    input wire logic sda_in, // Serial data level
    output logic sda_out, // Serial data drive value
    output logic sda_oe_n, // Serial data drive enable, low drives
    output logic alert_out, // Alert drive value
    output logic alert_oe_n, // Alert drive enable, low drives
    input wire logic chip_off_pin, // Chip disable pin level
    input wire fault_events_t events, // Fault conditions
    input wire analog_status_t status, // Analog status levels
    output logic reset_request, // Reset output, never masked
    output logic storage_request, // Ship mode request
    output logic charger_disable, // Charger disable bit
    output logic high_impedance_request, // High impedance bit
    output logic charging_allowed, // Charging permitted
    output logic thermistor_monitor_on, // Thermistor monitor enable
    output logic use_charge_resistor, // Resistor sets charge current
    output logic [8:0] charge_ma, // Charge current in mA
    output logic [15:0] finish_ua, // Finish current in uA
    output logic finish_cutoff_on, // Current termination active
    output logic [12:0] battery_target_mv, // Regulation voltage in mV
    output logic [7:0] output_voltage_control, // Output voltage setting
    output logic input_current_cap // Inferred input limit fault
);
    // Serial engine
    link_state_t state; // Engine state
    logic scl_prev; // Previous clock level
    logic sda_prev; // Previous data level
    logic [3:0] bit_cnt; // Bits in current byte
    logic [1:0] byte_no; // Byte index, saturates at 2
    logic [7:0] shift_in; // Receive shift register
    logic [7:0] shift_out; // Transmit shift register
    logic [7:0] ptr; // Register pointer
    logic rw; // Read transfer
    logic nack; // Master refused more data
    logic scl_rise; // Clock rising
    logic scl_fall; // Clock falling
    logic start_seen; // Start condition
    logic stop_seen; // Stop condition
    logic rd_load; // Byte loaded for read
    logic wr_strobe; // Data byte written
    logic [7:0] rd_byte; // Read mux
    // Registers
    logic [3:0] hide_fault; // Fault masks 3:0
    logic [7:0] therm_ctrl; // Thermistor control bits
    logic [7:0] fast_ctrl; // Fast charge control
    logic [7:0] finish_ctrl; // Termination control
    logic [7:0] vbat_ctrl; // Battery voltage control
    // Flags
    logic reset_fault; // Reset fault flag
    logic timer_fault; // Safety timer flag
    logic input_over_flag; // Input overvoltage flag
    logic input_under_flag; // Input undervoltage flag
    logic battery_lockout_flag; // Battery lockout flag
    logic battery_overcurrent_flag; // Battery overcurrent flag
    fault_events_t ev_prev; // Previous conditions
    fault_events_t ev_rise; // Rising conditions
    logic chip_off_prev; // Previous chip-off level
    logic clear_ok; // Deglitch clock running
    logic [4:0] pulse_cnt; // Alert pulse timer
    logic fault_alert; // Unmasked fault rising

    assign scl_rise = scl_in & ~scl_prev;
    assign scl_fall = ~scl_in & scl_prev;
    assign start_seen = scl_in & scl_prev & sda_prev & ~sda_in;
    assign stop_seen = scl_in & scl_prev & ~sda_prev & sda_in;
    assign rd_load = scl_fall & (((state == ST_ACK) & rw) | ((state == ST_RACK) & ~nack));
    assign wr_strobe = scl_fall & (state == ST_SHIFT) & (bit_cnt == 4'h8) & (byte_no == 2'h2)
        & ~rw;
    assign sda_out = 1'b0;
    assign alert_out = 1'b0;
    assign ev_rise = events & ~ev_prev;
    assign clear_ok = status.input_present | (status.battery_only & (state != ST_IDLE)); // [RQ15]

    // Charge current decode with clamp
    function automatic logic [8:0] charge_f(input logic span, input logic [4:0] code);
        int v;
        begin
            v = span ? CHG_BASE1_MA + CHG_STEP1_MA * int'(code)
                : CHG_BASE0_MA + CHG_STEP0_MA * int'(code); // [RQ16]
            if (!span && v > CHG_MAX0_MA)
                v = CHG_MAX0_MA; // [RQ17]
            if (span && v > CHG_MAX1_MA)
                v = CHG_MAX1_MA; // [RQ17]
            return 9'(v);
        end
    endfunction

    // Finish current decode with clamp
    function automatic logic [15:0] finish_f(input logic span, input logic [4:0] code);
        int v;
        begin
            v = span ? FIN_BASE1_UA + FIN_STEP1_UA * int'(code)
                : FIN_BASE0_UA + FIN_STEP0_UA * int'(code); // [RQ20]
            if (!span && v > FIN_MAX0_UA)
                v = FIN_MAX0_UA; // [RQ20]
            return 16'(v);
        end
    endfunction

    // Battery target decode with clamp
    function automatic logic [12:0] vbat_f(input logic [6:0] code, input logic warm);
        int v;
        begin
            v = VBAT_BASE_MV + VBAT_STEP_MV * int'(code); // [RQ22]
            if (v > VBAT_MAX_MV)
                v = VBAT_MAX_MV; // [RQ22]
            if (warm)
                v = v - WARM_DROP_MV; // [RQ12]
            return 13'(v);
        end
    endfunction

    // Read multiplexer
    always_comb
    begin
        case (ptr)
            REG_STATUS: rd_byte = {status.phase, 1'b0, reset_fault, timer_fault, // [RQ1] [RQ23]
                status.input_droop_active, chip_off_pin, status.switcher_on_flag}; // [RQ5]
            REG_FAULT: rd_byte = {input_over_flag, input_under_flag, battery_lockout_flag,
                battery_overcurrent_flag, hide_fault};
            REG_THERM: rd_byte = {therm_ctrl[7], status.zone, status.absent, therm_ctrl[3:0]};
            REG_FAST: rd_byte = fast_ctrl;
            REG_FINISH: rd_byte = finish_ctrl;
            REG_VBAT: rd_byte = vbat_ctrl;
            REG_VOUT: rd_byte = output_voltage_control;
            default: rd_byte = UNMAPPED_VALUE; // [RQ24]
        endcase
    end

    // Line sampling for edge detection
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            scl_prev <= scl_in;
            sda_prev <= sda_in;
        end
    end

    // Serial slave engine
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            byte_no <= 2'h0;
            shift_in <= 8'h00;
            shift_out <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe_n <= 1'b1;
        end
        else if (start_seen)
        begin
            // Start or repeated start restarts the frame
            state <= ST_SHIFT;
            bit_cnt <= 4'h0;
            byte_no <= 2'h0;
            sda_oe_n <= 1'b1;
        end
        else if (stop_seen)
        begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            case (state)
                ST_SHIFT:
                begin
                    if (scl_rise && bit_cnt != 4'h8)
                    begin
                        shift_in <= {shift_in[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == 4'h8)
                    begin
                        if (byte_no == 2'h0 && shift_in[7:1] != SLAVE_ADDR)
                            state <= ST_IDLE; // Not our address
                        else
                        begin
                            if (byte_no == 2'h0)
                                rw <= shift_in[0];
                            else if (byte_no == 2'h1)
                                ptr <= shift_in;
                            else
                                ptr <= ptr + 8'h01;
                            if (byte_no != 2'h2)
                                byte_no <= byte_no + 2'h1;
                            sda_oe_n <= 1'b0; // Acknowledge
                            state <= ST_ACK;
                        end
                    end
                end
                ST_ACK, ST_RACK:
                begin
                    if (scl_rise && state == ST_RACK)
                        nack <= sda_in;
                    else if (rd_load)
                    begin
                        shift_out <= {rd_byte[6:0], 1'b0};
                        sda_oe_n <= rd_byte[7];
                        bit_cnt <= 4'h1;
                        ptr <= ptr + 8'h01;
                        state <= ST_SEND;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe_n <= 1'b1;
                        bit_cnt <= 4'h0;
                        state <= (state == ST_RACK) ? ST_IDLE : ST_SHIFT;
                    end
                end
                ST_SEND:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'h8)
                        begin
                            sda_oe_n <= 1'b1;
                            state <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe_n <= shift_out[7];
                            shift_out <= {shift_out[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Host writable registers
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            storage_request <= 1'b0; // [RQ2]
            hide_fault <= RST_HIDE;
            therm_ctrl <= RST_THERM; // [RQ11]
            fast_ctrl <= RST_FAST;
            finish_ctrl <= RST_FINISH;
            vbat_ctrl <= RST_VBAT;
            output_voltage_control <= RST_VOUT;
        end
        else if (wr_strobe)
        begin
            case (ptr)
                REG_STATUS: storage_request <= shift_in[SHIP_BIT]; // [RQ2]
                REG_FAULT: hide_fault <= shift_in[3:0]; // [RQ9]
                REG_THERM: therm_ctrl <= {shift_in[7], 3'h0, shift_in[3:0]}; // [RQ11] [RQ14]
                REG_FAST: fast_ctrl <= shift_in; // [RQ19]
                REG_FINISH: finish_ctrl <= shift_in;
                REG_VBAT: vbat_ctrl <= shift_in;
                REG_VOUT: output_voltage_control <= shift_in;
                default: storage_request <= storage_request;
            endcase
        end
    end

    // Fault flags; a set in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ev_prev <= '0;
            chip_off_prev <= 1'b0;
            reset_fault <= 1'b0;
            timer_fault <= 1'b0;
            input_over_flag <= 1'b0;
            input_under_flag <= 1'b0;
            battery_lockout_flag <= 1'b0;
            battery_overcurrent_flag <= 1'b0;
        end
        else
        begin
            ev_prev <= events;
            chip_off_prev <= chip_off_pin;
            // Read of status clears the reset flag
            if (ev_rise.reset_cond)
                reset_fault <= 1'b1; // [RQ3]
            else if (rd_load && ptr == REG_STATUS)
                reset_fault <= 1'b0; // [RQ3]
            // Timer flag ignores reads, cleared by pin toggle
            if (ev_rise.timer)
                timer_fault <= 1'b1; // [RQ4]
            else if (chip_off_pin != chip_off_prev)
                timer_fault <= 1'b0; // [RQ4]
            // Read of the fault register
            if (events.over)
                input_over_flag <= 1'b1; // [RQ6]
            else if (rd_load && ptr == REG_FAULT && clear_ok)
                input_over_flag <= 1'b0; // [RQ6] [RQ15]
            if (ev_rise.under)
                input_under_flag <= 1'b1; // [RQ7]
            else if (rd_load && ptr == REG_FAULT)
                input_under_flag <= 1'b0; // [RQ7]
            if (events.lockout)
                battery_lockout_flag <= 1'b1; // [RQ8]
            else if (rd_load && ptr == REG_FAULT && clear_ok)
                battery_lockout_flag <= 1'b0; // [RQ8] [RQ15]
            if (ev_rise.overcurrent)
                battery_overcurrent_flag <= 1'b1; // [RQ3]
            else if (rd_load && ptr == REG_FAULT)
                battery_overcurrent_flag <= 1'b0; // [RQ3]
        end
    end

    // Unmasked fault rise starts an alert pulse
    assign fault_alert = (ev_rise.over & ~hide_fault[3]) | (ev_rise.under & ~hide_fault[2])
        | (ev_rise.lockout & ~hide_fault[1]) | (ev_rise.overcurrent & ~hide_fault[0])
        | (ev_rise.wake & ~therm_ctrl[2]) | (ev_rise.reset_cond & ~therm_ctrl[1])
        | (ev_rise.timer & ~therm_ctrl[0]); // [RQ9] [RQ25]

    // Alert pin and unmasked reset output
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pulse_cnt <= 5'h00;
            alert_oe_n <= 1'b1;
            reset_request <= 1'b0;
        end
        else
        begin
            if (fault_alert)
                pulse_cnt <= ALERT_PULSE_CYCLES; // [RQ25]
            else if (pulse_cnt != 5'h00)
                pulse_cnt <= pulse_cnt - 5'h01;
            alert_oe_n <= ~(fault_alert | (pulse_cnt > 5'h01)
                | (therm_ctrl[ALERT_STATUS_BIT] & status.phase == PHASE_CHARGING)); // [RQ14]
            reset_request <= events.reset_cond; // [RQ9]
        end
    end

    // Set-point decode and charge control outputs
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            charger_disable <= 1'b0;
            high_impedance_request <= 1'b0;
            charging_allowed <= 1'b0;
            thermistor_monitor_on <= 1'b1;
            use_charge_resistor <= 1'b0;
            charge_ma <= 9'h000;
            finish_ua <= 16'h0000;
            finish_cutoff_on <= 1'b0;
            battery_target_mv <= 13'h0000;
            input_current_cap <= 1'b0;
        end
        else
        begin
            charger_disable <= fast_ctrl[CE_BIT]; // [RQ19]
            high_impedance_request <= fast_ctrl[HZ_BIT]; // [RQ19]
            thermistor_monitor_on <= therm_ctrl[THERM_ON_BIT]; // [RQ11]
            charging_allowed <= ~fast_ctrl[CE_BIT] & ~fast_ctrl[HZ_BIT] // [RQ13] [RQ12]
                & ~(therm_ctrl[THERM_ON_BIT] & (status.absent | status.zone == ZONE_STOP));
            use_charge_resistor <= fast_ctrl[6:2] == CODE_EXTERNAL; // [RQ17]
            if (therm_ctrl[THERM_ON_BIT] && status.zone == ZONE_COOL)
                charge_ma <= charge_f(fast_ctrl[7], fast_ctrl[6:2]) >> 1; // [RQ12]
            else
                charge_ma <= charge_f(fast_ctrl[7], fast_ctrl[6:2]);
            finish_ua <= finish_f(finish_ctrl[7], finish_ctrl[6:2]);
            finish_cutoff_on <= finish_ctrl[CUTOFF_BIT] & ~status.other_loop
                & ~status.input_droop_active
                & ~(therm_ctrl[THERM_ON_BIT] & status.zone == ZONE_COOL); // [RQ21]
            battery_target_mv <= vbat_f(vbat_ctrl[7:1],
                therm_ctrl[THERM_ON_BIT] & status.zone == ZONE_WARM); // [RQ22]
            input_current_cap <= status.phase == PHASE_FAULT & ~input_over_flag
                & ~input_under_flag & ~battery_lockout_flag & ~battery_overcurrent_flag
                & ~reset_fault & ~timer_fault & status.zone == 2'h0 & ~status.absent; // [RQ10]
        end
    end

    property p_ship;
        @(posedge ref_clk) disable iff (!resetn)
        wr_strobe && ptr == REG_STATUS |=> storage_request == $past(shift_in[SHIP_BIT]);
    endproperty
    a_ship: assert property (p_ship) else $error("ship request not stored"); // [RQ2]

    property p_reset_set;
        @(posedge ref_clk) disable iff (!resetn)
        ev_rise.reset_cond |=> reset_fault;
    endproperty
    a_reset_set: assert property (p_reset_set) else $error("reset flag not set"); // [RQ3]

    property p_timer_hold;
        @(posedge ref_clk) disable iff (!resetn)
        timer_fault && chip_off_pin == chip_off_prev |=> timer_fault;
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer flag lost"); // [RQ4]

    property p_over_hold;
        @(posedge ref_clk) disable iff (!resetn)
        events.over |=> input_over_flag;
    endproperty
    a_over_hold: assert property (p_over_hold) else $error("overvoltage flag lost"); // [RQ6]

    property p_lock_hold;
        @(posedge ref_clk) disable iff (!resetn)
        events.lockout |=> battery_lockout_flag;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lockout flag lost"); // [RQ8]

    property p_alert;
        @(posedge ref_clk) disable iff (!resetn)
        ev_rise.overcurrent && !hide_fault[0] |=> !alert_oe_n [*8];
    endproperty
    a_alert: assert property (p_alert) else $error("alert pulse missing"); // [RQ25]

    property p_clamp;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 charge_ma <= 9'(CHG_MAX1_MA) && battery_target_mv <= 13'(VBAT_MAX_MV);
    endproperty
    a_clamp: assert property (p_clamp) else $error("set point above clamp"); // [RQ17]

    property p_unmapped;
        @(posedge ref_clk) disable iff (!resetn)
        rd_load && ptr > REG_VOUT |=> sda_oe_n && shift_out == 8'hfe;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not ones"); // [RQ24]

    property p_input_current_cap;
        @(posedge ref_clk) disable iff (!resetn)
        input_current_cap |-> $past(status.phase) == PHASE_FAULT;
    endproperty
    a_input_current_cap: assert property (p_input_current_cap) else $error("input limit without fault"); // [RQ10]
endmodule
`default_nettype wire

// ===== test/i2c_host.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
    input wire logic ref_clk, // System clock
    input wire logic sda_line, // Resolved data line
    output logic scl, // Clock drive
    output logic sda_m // Data drive, 1 releases it
);
    // Both lines idle high
    initial scl = 1'b1;
    initial sda_m = 1'b1;
    // Each line change waits four falling edges
    task automatic hold();
        repeat (4) @(negedge ref_clk);
    endtask
    // Start or repeated start: data falls with clock high
    task automatic start();
        sda_m = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_m = 1'b0;
        hold();
        scl = 1'b0;
    endtask
    // Stop: data rises with clock high
    task automatic stop();
        hold();
        sda_m = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_m = 1'b1;
        hold();
    endtask
    // Eight bits plus acknowledge, first bit most significant
    task automatic nine(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            hold();
            sda_m = w[i];
            hold();
            scl = 1'b1;
            hold();
            r[i] = sda_line;
            scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== test/charger_status_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module charger_status_config_regs_test import charger_regs_pkg::*;;
    logic ref_clk = 1'b0; // Clock
    logic resetn = 1'b0; // Reset, active low
    logic chip_off_pin = 1'b0; // Chip disable level
    fault_events_t events = '0; // Fault conditions
    analog_status_t status = '0; // Analog levels
    wire logic scl, sda_m, sda, sda_out, sda_oe_n, alert_oe_n, ship, cdis, hiz, ok, ext;
    wire logic icap, rreq, cut; // Limit fault, reset out, cutoff
    wire logic [8:0] ma; // Charge current
    wire logic [15:0] ua; // Finish current
    wire logic [12:0] mv; // Battery target
    int errors = 0;
    int checks_done = 0;
    // Open-drain data line with pull-up
    assign sda = sda_m & (sda_oe_n | sda_out);
    always #2.5 ref_clk = ~ref_clk;
    i2c_host i_i2c_host (.ref_clk(ref_clk), .sda_line(sda), .scl(scl), .sda_m(sda_m));
    charger_status_config_regs i_charger_status_config_regs (.ref_clk(ref_clk),
        .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .alert_out(), .alert_oe_n(alert_oe_n), .chip_off_pin(chip_off_pin), .events(events),
        .status(status), .reset_request(rreq), .storage_request(ship), .charger_disable(cdis),
        .high_impedance_request(hiz), .charging_allowed(ok), .thermistor_monitor_on(),
        .use_charge_resistor(ext), .charge_ma(ma), .finish_ua(ua), .finish_cutoff_on(cut),
        .battery_target_mv(mv), .output_voltage_control(), .input_current_cap(icap));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Register write: address, pointer, data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        i_i2c_host.start();
        i_i2c_host.nine({8'hd4, 1'b1}, r);
        i_i2c_host.nine({a, 1'b1}, r);
        i_i2c_host.nine({d, 1'b1}, r);
        chk("ack", 16'h0000, {15'h0000, r[0]});
        i_i2c_host.stop();
    endtask
    // Register read with repeated start, masked compare
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        logic [8:0] r;
        i_i2c_host.start();
        i_i2c_host.nine({8'hd4, 1'b1}, r);
        i_i2c_host.nine({a, 1'b1}, r);
        i_i2c_host.start();
        i_i2c_host.nine({8'hd5, 1'b1}, r);
        i_i2c_host.nine(9'h1ff, r);
        i_i2c_host.stop();
        chk(n, {8'h00, e}, {8'h00, r[8:1] & m});
    endtask
    task automatic t_reset();
        rc("fast", 8'h03, 8'hff, 8'h14);
        rc("finish", 8'h04, 8'hff, 8'h0e);
        rc("vbat", 8'h05, 8'hff, 8'h78);
        rc("therm", 8'h02, 8'hff, 8'h88);
        rc("unmapped", 8'h07, 8'hff, 8'hff);
        chk("charge_ma", 16'h000a, 16'(ma));
        chk("finish_ua", 16'h07d0, ua);
        chk("target_mv", 16'h1068, 16'(mv));
        chk("cutoff", 16'h0001, 16'(cut));
        $display("reset test done");
    endtask
    task automatic t_codes();
        wr(8'h03, 8'hf8);
        chk("clamp_ma", 16'h012c, 16'(ma));
        wr(8'h05, 8'hfe);
        chk("clamp_mv", 16'h122a, 16'(mv));
        wr(8'h04, 8'h04);
        wr(8'h03, 8'h7f);
        chk("resistor", 16'h0001, 16'(ext));
        chk("fast_bits", 16'h0003, {14'h0000, cdis, hiz});
        chk("allowed", 16'h0000, 16'(ok));
        chk("finish_ua", 16'h03e8, ua);
        $display("code test done");
    endtask
    task automatic t_ship();
        wr(8'h00, 8'h20);
        chk("ship", 16'h0001, 16'(ship));
        chip_off_pin = 1'b1;
        status.phase = 2'h3;
        rc("status", 8'h00, 8'he2, 8'hc2);
        chk("input_current_cap", 16'h0001, 16'(icap));
        $display("ship test done");
    endtask
    task automatic t_flags();
        status.input_present = 1'b1;
        events.overcurrent = 1'b1;
        events.over = 1'b1;
        events.timer = 1'b1;
        events.reset_cond = 1'b1;
        events.under = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("alert", 16'h0000, 16'(alert_oe_n));
        chk("reset_out", 16'h0001, 16'(rreq));
        rc("fault", 8'h01, 8'hd0, 8'hd0);
        rc("fault_again", 8'h01, 8'hd0, 8'h80);
        rc("timer", 8'h00, 8'h18, 8'h18);
        rc("timer_again", 8'h00, 8'h18, 8'h08);
        chip_off_pin = 1'b0;
        rc("timer_clr", 8'h00, 8'h08, 8'h00);
        $display("flag test done");
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial
    begin
        #400000;
        errors++;
        final_report();
    end
    initial
    begin
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_codes();
        t_ship();
        t_flags();
        final_report();
    end
endmodule
`default_nettype wire
